//--- hw/icsf_pkg.sv
// Contract
// - Master on makes the six optional chunk kinds enableable.
// - Master switch on turns on the extended image-data chunk by itself.
// - Master switch off stops every trailing chunk on later images.
// - Master switch on marks payload type as pixels plus trailer.
// - Extended chunk holds region offsets, size, pixel format, range limits.
// - Extended chunk is appended to every acquired image while enabled.
// - Frame count is a 32-bit unsigned counter.
// - Frame count starts at zero and adds one per acquired frame.
// - At maximum the frame count rolls to zero on the next frame.
// - Per-chunk enables are ignored while the master switch is clear.
// - Frame-count chunk on by selecting its kind, then setting enable.
// - Frame counts may be skipped on stop; consumers tolerate gaps.
// - Frame count returns to zero on power loss or reset.
// - Clear source selectable: software, input one, input two, or none.
// - Clear source defaults to none after reset.
// - Software clear command acts only when clear source is software.
// - Trigger count starts at one, frame count at zero; pair differs by one.
// - Frame count advances only for triggers that actually make a frame.
package icsf_pkg;

  // Register offsets
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_CHUNK     = 4'h1;
  localparam logic [3:0] REG_COUNTER   = 4'h2;
  localparam logic [3:0] REG_CMD       = 4'h3;
  localparam logic [3:0] REG_OFFSET    = 4'h4;
  localparam logic [3:0] REG_SIZE      = 4'h5;
  localparam logic [3:0] REG_FORMAT    = 4'h6;
  localparam logic [3:0] REG_RANGE     = 4'h7;
  localparam logic [3:0] REG_FRAMECNT  = 4'h8;
  localparam logic [3:0] REG_TRIGCNT   = 4'h9;
  localparam logic [3:0] REG_STATUS    = 4'ha;

  // Chunk kinds, index into the enable vector
  localparam int          NUM_KINDS     = 6;
  localparam logic [2:0]  KIND_FRAMECNT = 3'h0;
  localparam logic [2:0]  KIND_TRIGCNT  = 3'h1;
  localparam logic [2:0]  KIND_STAMP    = 3'h2;
  localparam logic [2:0]  KIND_LINES    = 3'h3;
  localparam logic [2:0]  KIND_CHECKSUM = 3'h4;
  localparam logic [2:0]  KIND_SEQINDEX = 3'h5;

  // Counter instances and increment sources
  localparam logic [1:0]  INST_TRIGGER  = 2'h1;
  localparam logic [1:0]  INST_FRAME    = 2'h2;
  localparam logic [1:0]  SRC_TRIGGER   = 2'h1;
  localparam logic [1:0]  SRC_FRAME     = 2'h2;

  // Reset values and synchroniser depth
  localparam logic [31:0] FRAME_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] TRIG_CNT_RST  = 32'h0000_0001;
  localparam int          SYNC_STAGES   = 2;

  typedef enum logic [1:0] {
    CLR_NONE     = 2'h0,
    CLR_SOFTWARE = 2'h1,
    CLR_LINE_ONE = 2'h2,
    CLR_LINE_TWO = 2'h3
  } icsf_clr_src_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PIXELS  = 2'b01,
    ST_TRAILER = 2'b11
  } icsf_state_t;

  // Extended image data carried with every frame while the master switch is on
  typedef struct packed {
    logic [15:0] offset_x;
    logic [15:0] offset_y;
    logic [15:0] width;
    logic [15:0] height;
    logic [31:0] pixel_format;
    logic [15:0] range_min;
    logic [15:0] range_max;
  } icsf_ext_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } icsf_req_t;

endpackage

//--- hw/icsf_line_edge.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by a rising-edge detector
module icsf_line_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Line
  input  wire logic line_in,
  output logic      rise
);
  logic [icsf_pkg::SYNC_STAGES-1:0] sync_q;
  logic                             last_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_q <= '0;
      last_q <= 1'b0;
      rise   <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], line_in};
      last_q <= sync_q[1];
      rise   <= sync_q[1] & ~last_q;
    end
  end
endmodule

//--- hw/icsf_framer.sv
`timescale 1ns/1ps
// Appends trailer words after each frame's pixel words while the master switch is on
module icsf_framer #(
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Register port
  input  wire icsf_pkg::icsf_req_t req,
  output logic [31:0]              rdata,
  // Acquisition events
  input  wire logic                trigger_in,
  input  wire logic                frame_begin_event,
  input  wire logic                io_input_one,
  input  wire logic                io_input_two,
  // Pixel stream in
  input  wire logic                pix_valid,
  input  wire logic [DW-1:0]       pix_data,
  input  wire logic                pix_last,
  // Stream out
  output logic                     out_valid,
  output logic [DW-1:0]            out_data,
  output logic                     out_last,
  output logic                     out_is_trailer,
  output logic                     payload_with_trailer
);
  logic                    chunk_master_switch_q;
  logic [2:0]              chunk_kind_select_q;
  logic [icsf_pkg::NUM_KINDS-1:0] chunk_kind_enable_q;
  logic [1:0]              counter_instance_select_q;
  logic [1:0]              frame_src_q;
  logic [1:0]              trig_src_q;
  icsf_pkg::icsf_clr_src_t counter_clear_source_q;
  icsf_pkg::icsf_ext_t     ext_q;
  logic [31:0]             frame_cnt_q;
  logic [31:0]             trig_cnt_q;
  logic [31:0]             trig_snap_q;
  logic [31:0]             frame_snap_q;
  icsf_pkg::icsf_state_t   state_q;
  logic [3:0]              word_q;
  logic [3:0]              last_word_q;
  logic                    rise_one;
  logic                    rise_two;
  logic                    sw_clear;
  logic                    line_clear;
  logic                    frame_clear;
  logic [icsf_pkg::NUM_KINDS-1:0] kinds_live;

  // Shared decode of write hits
  function automatic logic wr_hit(input icsf_pkg::icsf_req_t r,
                                  input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  icsf_line_edge u_edge_one (
    .clk     (clk),
    .reset   (reset),
    .line_in (io_input_one),
    .rise    (rise_one)
  );

  icsf_line_edge u_edge_two (
    .clk     (clk),
    .reset   (reset),
    .line_in (io_input_two),
    .rise    (rise_two)
  );

  // Enables count only behind the master switch
  assign kinds_live = chunk_master_switch_q ?
                      chunk_kind_enable_q : '0;

  // Control and configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      chunk_master_switch_q     <= 1'b0;
      chunk_kind_select_q       <= 3'h0;
      chunk_kind_enable_q       <= '0;
      counter_instance_select_q <= icsf_pkg::INST_FRAME;
      frame_src_q               <= icsf_pkg::SRC_FRAME;
      trig_src_q                <= icsf_pkg::SRC_TRIGGER;
      counter_clear_source_q    <= icsf_pkg::CLR_NONE;
      payload_with_trailer      <= 1'b0;
    end else begin
      if (wr_hit(req, icsf_pkg::REG_CTRL)) begin
        chunk_master_switch_q <= req.wdata[0];
        payload_with_trailer  <= req.wdata[0];
        if (!req.wdata[0])
          chunk_kind_enable_q <= '0;
      end
      if (wr_hit(req, icsf_pkg::REG_CHUNK)) begin
        chunk_kind_select_q <= req.wdata[2:0];
        // Enable applies to the kind named in the same write
        if (chunk_master_switch_q &&
            req.wdata[2:0] < 3'(icsf_pkg::NUM_KINDS))
          chunk_kind_enable_q[req.wdata[2:0]] <= req.wdata[8];
      end
      if (wr_hit(req, icsf_pkg::REG_COUNTER)) begin
        counter_instance_select_q <= req.wdata[1:0];
        if (req.wdata[1:0] == icsf_pkg::INST_FRAME) begin
          frame_src_q <= req.wdata[5:4];
          counter_clear_source_q <=
            icsf_pkg::icsf_clr_src_t'(req.wdata[9:8]);
        end
        if (req.wdata[1:0] == icsf_pkg::INST_TRIGGER)
          trig_src_q <= req.wdata[5:4];
      end
    end
  end

  // Image description registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_q <= '0;
    end else begin
      if (wr_hit(req, icsf_pkg::REG_OFFSET))
        {ext_q.offset_y, ext_q.offset_x} <= req.wdata;
      if (wr_hit(req, icsf_pkg::REG_SIZE))
        {ext_q.height, ext_q.width} <= req.wdata;
      if (wr_hit(req, icsf_pkg::REG_FORMAT))
        ext_q.pixel_format <= req.wdata;
      if (wr_hit(req, icsf_pkg::REG_RANGE))
        {ext_q.range_max, ext_q.range_min} <= req.wdata;
    end
  end

  // Clear sources; software command is ignored unless chosen
  assign sw_clear   = wr_hit(req, icsf_pkg::REG_CMD) && req.wdata[0] &&
                      counter_clear_source_q ==
                      icsf_pkg::CLR_SOFTWARE;
  assign line_clear =
    (counter_clear_source_q == icsf_pkg::CLR_LINE_ONE && rise_one) ||
    (counter_clear_source_q == icsf_pkg::CLR_LINE_TWO && rise_two);
  assign frame_clear = sw_clear || line_clear;

  // Frame counter: 32-bit, counts real frame starts, wraps naturally
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt_q <= icsf_pkg::FRAME_CNT_RST;
    end else if (frame_clear) begin
      frame_cnt_q <= icsf_pkg::FRAME_CNT_RST;
    end else if (frame_begin_event &&
                 frame_src_q == icsf_pkg::SRC_FRAME) begin
      frame_cnt_q <= frame_cnt_q + 32'h1;
    end
  end

  // Trigger counter starts one ahead of the frame counter
  always_ff @(posedge clk) begin
    if (reset)
      trig_cnt_q <= icsf_pkg::TRIG_CNT_RST;
    else if (trigger_in && trig_src_q == icsf_pkg::SRC_TRIGGER)
      trig_cnt_q <= trig_cnt_q + 32'h1;
  end

  // Trigger number taken before the step, so it pairs with the frame word
  always_ff @(posedge clk) begin
    if (reset)
      trig_snap_q <= '0;
    else if (trigger_in && trig_src_q == icsf_pkg::SRC_TRIGGER)
      trig_snap_q <= trig_cnt_q;
  end

  // Trailer word picker: extended chunk then optional counter words
  function automatic logic [31:0] trailer_word(input logic [3:0] w);
    case (w)
      4'h0:    return {ext_q.offset_y, ext_q.offset_x};
      4'h1:    return {ext_q.height, ext_q.width};
      4'h2:    return ext_q.pixel_format;
      4'h3:    return {ext_q.range_max, ext_q.range_min};
      4'h4:    return frame_snap_q;
      default: return trig_snap_q;
    endcase
  endfunction

  // Frame sequencer; counter value is snapped at frame begin.
  // Stopping mid-stream may drop counts, which hosts must accept.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q        <= icsf_pkg::ST_IDLE;
      word_q         <= 4'h0;
      last_word_q    <= 4'h3;
      frame_snap_q   <= '0;
      out_valid      <= 1'b0;
      out_data       <= '0;
      out_last       <= 1'b0;
      out_is_trailer <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
      if (frame_begin_event)
        frame_snap_q <= frame_cnt_q;
      unique case (state_q)
        icsf_pkg::ST_IDLE, icsf_pkg::ST_PIXELS: begin
          out_is_trailer <= 1'b0;
          if (pix_valid) begin
            state_q   <= icsf_pkg::ST_PIXELS;
            out_valid <= 1'b1;
            out_data  <= DW'(pix_data);
            if (pix_last) begin
              word_q <= 4'h0;
              last_word_q <= kinds_live[icsf_pkg::KIND_TRIGCNT] ? 4'h5 :
                             kinds_live[icsf_pkg::KIND_FRAMECNT] ? 4'h4 :
                             4'h3;
              if (chunk_master_switch_q) begin
                state_q <= icsf_pkg::ST_TRAILER;
              end else begin
                state_q  <= icsf_pkg::ST_IDLE;
                out_last <= 1'b1;
              end
            end
          end
        end
        icsf_pkg::ST_TRAILER: begin
          out_valid      <= 1'b1;
          out_is_trailer <= 1'b1;
          out_data       <= DW'(trailer_word(word_q));
          // Skip the frame word when only the trigger word is on
          if (word_q == 4'h3 && !kinds_live[icsf_pkg::KIND_FRAMECNT])
            word_q <= 4'h5;
          else
            word_q <= word_q + 4'h1;
          if (word_q == last_word_q) begin
            out_last <= 1'b1;
            state_q  <= icsf_pkg::ST_IDLE;
          end
        end
        default: state_q <= icsf_pkg::ST_IDLE;
      endcase
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        icsf_pkg::REG_CTRL:     rdata <= {31'h0, chunk_master_switch_q};
        icsf_pkg::REG_CHUNK:    rdata <= {23'h0,
                                   kinds_live[chunk_kind_select_q < 3'h6 ?
                                   chunk_kind_select_q : 3'h0],
                                   5'h0, chunk_kind_select_q};
        icsf_pkg::REG_COUNTER:  rdata <= {22'h0, counter_clear_source_q,
                                   2'h0, frame_src_q, 2'h0,
                                   counter_instance_select_q};
        icsf_pkg::REG_OFFSET:   rdata <= {ext_q.offset_y, ext_q.offset_x};
        icsf_pkg::REG_SIZE:     rdata <= {ext_q.height, ext_q.width};
        icsf_pkg::REG_FORMAT:   rdata <= ext_q.pixel_format;
        icsf_pkg::REG_RANGE:    rdata <= {ext_q.range_max, ext_q.range_min};
        icsf_pkg::REG_FRAMECNT: rdata <= frame_cnt_q;
        icsf_pkg::REG_TRIGCNT:  rdata <= trig_cnt_q;
        icsf_pkg::REG_STATUS:   rdata <= {24'h0, 2'h0, kinds_live};
        default:                rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Checks
  property p_switch_off_no_trailer;
    @(posedge clk) disable iff (reset)
      (!chunk_master_switch_q && state_q != icsf_pkg::ST_TRAILER)
      |=> state_q != icsf_pkg::ST_TRAILER;
  endproperty
  a_switch_off_no_trailer: assert property (p_switch_off_no_trailer)
    else $error("trailer started with master switch off");

  property p_enable_gated;
    @(posedge clk) disable iff (reset)
      !chunk_master_switch_q |-> chunk_kind_enable_q == '0;
  endproperty
  a_enable_gated: assert property (p_enable_gated)
    else $error("chunk enable live with master off");

  property p_payload;
    @(posedge clk) disable iff (reset)
      payload_with_trailer == chunk_master_switch_q;
  endproperty
  a_payload: assert property (p_payload)
    else $error("payload type mismatch");

  property p_count_step;
    @(posedge clk) disable iff (reset)
      (frame_begin_event && !frame_clear &&
       frame_src_q == icsf_pkg::SRC_FRAME)
      |=> frame_cnt_q == $past(frame_cnt_q) + 32'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("frame count did not step by one");

  property p_wrap;
    @(posedge clk) disable iff (reset)
      (frame_cnt_q == 32'hffff_ffff && frame_begin_event &&
       frame_src_q == icsf_pkg::SRC_FRAME) |=> frame_cnt_q == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("frame count did not wrap");

  property p_hold;
    @(posedge clk) disable iff (reset)
      (!frame_begin_event && !frame_clear) |=> $stable(frame_cnt_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame count moved without a frame");

  property p_sw_clear;
    @(posedge clk) disable iff (reset)
      (wr_hit(req, icsf_pkg::REG_CMD) && req.wdata[0] &&
       counter_clear_source_q != icsf_pkg::CLR_SOFTWARE &&
       !line_clear && !frame_begin_event) |=> $stable(frame_cnt_q);
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software clear acted with other source");

  property p_ext_first;
    @(posedge clk) disable iff (reset)
      (state_q != icsf_pkg::ST_TRAILER) ##1
      (state_q == icsf_pkg::ST_TRAILER) |=> out_valid && out_is_trailer
      && out_data == DW'({ext_q.offset_y, ext_q.offset_x});
  endproperty
  a_ext_first: assert property (p_ext_first)
    else $error("extended chunk not first trailer word");

  property p_trig_pair;
    @(posedge clk) disable iff (reset)
      (trigger_in && trig_src_q == icsf_pkg::SRC_TRIGGER)
      |=> trig_snap_q == $past(trig_cnt_q) &&
          trig_cnt_q == $past(trig_cnt_q) + 32'h1;
  endproperty
  a_trig_pair: assert property (p_trig_pair)
    else $error("trigger number not taken before the step");

  property p_line_clear;
    @(posedge clk) disable iff (reset)
      (counter_clear_source_q == icsf_pkg::CLR_LINE_ONE && rise_one)
      |=> frame_cnt_q == icsf_pkg::FRAME_CNT_RST;
  endproperty
  a_line_clear: assert property (p_line_clear)
    else $error("line edge did not clear the frame count");

  c_trailer: cover property (@(posedge clk) disable iff (reset)
    out_is_trailer && out_last);
  c_plain: cover property (@(posedge clk) disable iff (reset)
    !out_is_trailer && out_last);
  c_line_clear: cover property (@(posedge clk) disable iff (reset)
    line_clear);
endmodule

//--- testbench/icsf_host_model.sv
`timescale 1ns/1ps
// Host-side receiver: counts frames and flags misplaced trailer words
module icsf_host_model (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  // Stream from the camera
  input  wire logic   out_valid,
  input  wire logic   out_last,
  input  wire logic   out_is_trailer,
  input  wire logic   payload_with_trailer,
  // Receiver status
  output logic [31:0] frames_q,
  output logic        bad_q
);
  // Frame numbers are never checked for continuity, so gaps are fine
  always_ff @(posedge clk) begin
    if (reset) begin
      frames_q <= 32'h0;
    end else if (out_valid && out_last) begin
      frames_q <= frames_q + 32'h1;
    end
  end

  // A trailer word under a plain payload type breaks the host parser
  always_ff @(posedge clk) begin
    if (reset) begin
      bad_q <= 1'b0;
    end else if (out_valid && out_is_trailer && !payload_with_trailer) begin
      bad_q <= 1'b1;
    end
  end
endmodule

//--- testbench/image_chunk_stamp_frame_counter_test.sv
`timescale 1ns/1ps
// Drives registers, events and pixels; checks reads and the output stream
module image_chunk_stamp_frame_counter_test;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  icsf_pkg::icsf_req_t req = '0;
  logic [31:0]         rdata;
  logic                trigger_in = 1'b0;
  logic                frame_begin_event = 1'b0;
  logic                io_input_one = 1'b0;
  logic                io_input_two = 1'b0;
  logic                pix_valid = 1'b0;
  logic [31:0]         pix_data = 32'h0;
  logic                pix_last = 1'b0;
  logic                out_valid, out_last, out_is_trailer;
  logic [31:0]         out_data;
  logic                payload_with_trailer;
  logic [31:0]         host_frames;
  logic                host_bad;
  // Expectations and reference state
  logic [31:0]         rq[$];
  logic [33:0]         sq[$];
  logic                rd_d = 1'b0;
  int                  errors = 0;
  int                  compares = 0;
  logic [31:0]         fc = 32'h0, tc = 32'h1, nf = 32'h0;
  logic                master = 1'b0, fk = 1'b0, tk = 1'b0;
  logic [31:0]         ext [4];
  logic [5:0]          live = 6'h0;

  always #5 clk = ~clk;

  icsf_framer #(.DW(32)) u_dut (
    .clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .trigger_in(trigger_in), .frame_begin_event(frame_begin_event),
    .io_input_one(io_input_one), .io_input_two(io_input_two),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_last(pix_last),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_is_trailer(out_is_trailer),
    .payload_with_trailer(payload_with_trailer));

  icsf_host_model u_host (
    .clk(clk), .reset(reset), .out_valid(out_valid), .out_last(out_last),
    .out_is_trailer(out_is_trailer),
    .payload_with_trailer(payload_with_trailer),
    .frames_q(host_frames), .bad_q(host_bad));

  // Shared mismatch report
  task automatic note(string n, logic [33:0] e, logic [33:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_rd(string n, logic [31:0] e, logic [31:0] g);
    note(n, {2'h0, e}, {2'h0, g});
  endtask
  task automatic cmp_out(string n, logic [33:0] e, logic [33:0] g);
    note(n, e, g);
  endtask
  task automatic cmp_flag(string n, logic e, logic g);
    note(n, {33'h0, e}, {33'h0, g});
  endtask

  task automatic conclude();
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle register strobe; a cycle passes before the next one
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Notes the expected words first, then sends the frame
  task automatic frame(int n, logic trig);
    logic [31:0] d [8];
    for (int i = 0; i < n; i++) begin
      d[i] = $urandom();
      sq.push_back({!master && i == n - 1, 1'b0, d[i]});
    end
    if (master) begin
      for (int i = 0; i < 4; i++)
        sq.push_back({!fk && !tk && i == 3, 1'b1, ext[i]});
      if (fk) sq.push_back({!tk, 1'b1, fc});
      if (tk) sq.push_back({1'b1, 1'b1, tc});
    end
    @(posedge clk);
    frame_begin_event <= 1'b1;
    trigger_in <= trig;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      frame_begin_event <= 1'b0;
      trigger_in <= 1'b0;
      pix_valid <= 1'b1;
      pix_data <= d[i];
      pix_last <= (i == n - 1);
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    pix_last <= 1'b0;
    fc += 32'h1;
    nf += 32'h1;
    if (trig) tc += 32'h1;
    repeat (8) @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe; stream words too
  always @(posedge clk) begin
    if (rd_d) cmp_rd("rdata", rq.pop_front(), rdata);
    rd_d <= req.rd;
    if (out_valid)
      cmp_out("stream", sq.size() > 0 ? sq.pop_front() : 34'hx,
              {out_last, out_is_trailer, out_data});
  end

  initial begin
    #300us;
    errors++;
    conclude();
  end

  initial begin
    void'($urandom(15426));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      ext[i] = $urandom();
      bus(1'b1, icsf_pkg::REG_OFFSET + 4'(i), ext[i]);
    end
    bus(1'b1, icsf_pkg::REG_COUNTER, 32'h22);
    rd(icsf_pkg::REG_FRAMECNT, 32'h0);
    rd(icsf_pkg::REG_TRIGCNT, 32'h1);
    frame(3, 1'b1);
    cmp_flag("payload_with_trailer", 1'b0, payload_with_trailer);
    bus(1'b1, icsf_pkg::REG_CHUNK, 32'h100);
    rd(icsf_pkg::REG_STATUS, 32'h0);
    master = 1'b1;
    bus(1'b1, icsf_pkg::REG_CTRL, 32'h1);
    @(negedge clk);
    cmp_flag("payload_with_trailer", 1'b1, payload_with_trailer);
    frame(2, 1'b1);
    // Every chunk kind becomes enableable once the master switch is on
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, icsf_pkg::REG_CHUNK, 32'h100 | 32'(k));
      live[k] = 1'b1;
      rd(icsf_pkg::REG_STATUS, {26'h0, live});
    end
    bus(1'b1, icsf_pkg::REG_CHUNK, 32'h106);
    rd(icsf_pkg::REG_STATUS, 32'h3f);
    master = 1'b0;
    bus(1'b1, icsf_pkg::REG_CTRL, 32'h0);
    rd(icsf_pkg::REG_STATUS, 32'h0);
    master = 1'b1;
    bus(1'b1, icsf_pkg::REG_CTRL, 32'h1);
    bus(1'b1, icsf_pkg::REG_CHUNK, 32'h100 | 32'(icsf_pkg::KIND_FRAMECNT));
    fk = 1'b1;
    frame(4, 1'b1);
    bus(1'b1, icsf_pkg::REG_CHUNK, 32'h100 | 32'(icsf_pkg::KIND_TRIGCNT));
    tk = 1'b1;
    frame(1, 1'b1);
    frame(2, 1'b1);
    // A trigger that makes no frame moves only the trigger count, so the
    // next frame's trigger word runs two ahead of its frame word
    @(posedge clk);
    trigger_in <= 1'b1;
    @(posedge clk);
    trigger_in <= 1'b0;
    tc += 32'h1;
    frame(2, 1'b1);
    rd(icsf_pkg::REG_TRIGCNT, tc);
    rd(icsf_pkg::REG_FRAMECNT, fc);
    bus(1'b1, icsf_pkg::REG_CMD, 32'h1);
    rd(icsf_pkg::REG_FRAMECNT, fc);
    bus(1'b1, icsf_pkg::REG_COUNTER, 32'h122);
    bus(1'b1, icsf_pkg::REG_CMD, 32'h1);
    fc = 32'h0;
    rd(icsf_pkg::REG_FRAMECNT, fc);
    // Line sources: the other line must not clear, the chosen one must
    for (int s = 2; s < 4; s++) begin
      frame(1, 1'b1);
      bus(1'b1, icsf_pkg::REG_COUNTER, 32'h22 | 32'(s << 8));
      io_input_one <= (s == 3);
      io_input_two <= (s == 2);
      repeat (6) @(posedge clk);
      rd(icsf_pkg::REG_FRAMECNT, fc);
      io_input_one <= (s == 2);
      io_input_two <= (s == 3);
      repeat (6) @(posedge clk);
      fc = 32'h0;
      rd(icsf_pkg::REG_FRAMECNT, fc);
      io_input_one <= 1'b0;
      io_input_two <= 1'b0;
    end
    frame(2, 1'b1);
    repeat (4) @(posedge clk);
    cmp_rd("host frames", nf, host_frames);
    cmp_flag("host fault", 1'b0, host_bad);
    cmp_rd("words left", 32'h0, 32'(sq.size()));
    conclude();
  end
endmodule
